// File: logic/flash_host_pkg.sv
package flash_host_pkg;
   // ==========================================================
   // clock and widths
   localparam int CLK_PERIOD_NS = 50;
   localparam int ADDR_W        = 21;
   localparam int DATA_W        = 16;
   localparam int CMD_W         = 8;
   localparam int BANK_HI       = 20;
   localparam int BANK_LO       = 15;
   localparam int BANK_W        = BANK_HI - BANK_LO + 1;
   // ==========================================================
   // pin timing in ns
   localparam int WE_LOW_NS          = 40;
   localparam int WE_HIGH_NS         = 20;
   localparam int ACCESS_NS          = 80;
   localparam int RESET_PULSE_MIN_NS = 500;
   localparam int RESET_READY_NS     = 20000;
   // least times round up to whole cycles
   function automatic logic [8:0] cyc_up(input int ns);
      return 9'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   endfunction
   localparam logic [8:0] WE_LOW_CYC      = cyc_up(WE_LOW_NS);
   localparam logic [8:0] WE_HIGH_CYC     = cyc_up(WE_HIGH_NS);
   localparam logic [8:0] ACCESS_CYC      = cyc_up(ACCESS_NS);
   localparam logic [8:0] RESET_PULSE_CYC = cyc_up(RESET_PULSE_MIN_NS);
   localparam logic [8:0] RESET_READY_CYC = cyc_up(RESET_READY_NS);
   localparam logic [8:0] CNT_ONE         = 9'h001;
   localparam logic [8:0] CNT_SAT         = 9'h1FF;
   // ==========================================================
   // user requests and pins
   typedef enum logic [2:0] {
      OP_READ,
      OP_WRITE,
      OP_SW_RESET,
      OP_HW_RESET,
      OP_ID_ENTER
   } op_t;
   typedef struct packed {
      op_t                 op;
      logic                start_op;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } req_t;
   typedef struct packed {
      logic                flash_chip_select_n;
      logic                oe_n;
      logic                we_n;
      logic                reset_n;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   dq_out;
      logic                dq_oe;
   } pins_t;
endpackage

// File: logic/flash_host_ctrl.sv
// Operation
// - host does not read other addresses of a bank that is busy
// - first read after power-up follows reset or select going low
// - id read affects one bank, its base given on the third write
// - host writes by strobe pulse with select low, enable high
// - host holds reset low at least 500 ns
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl #(
   parameter logic [7:0]  CMD_RESET     = 8'hF0,
   parameter logic [7:0]  CMD_UNLOCK_A  = 8'hAA,
   parameter logic [7:0]  CMD_UNLOCK_B  = 8'h55,
   parameter logic [7:0]  CMD_ID        = 8'h90,
   parameter logic [20:0] UNLOCK_ADDR_A = 21'h000555,
   parameter logic [20:0] UNLOCK_ADDR_B = 21'h0002AA
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   // user requests
   input  wire logic                  req_valid,
   input  wire flash_host_pkg::req_t  req,
   output var  logic                  req_ready,
   input  wire logic                  op_done,
   // user answers
   output var  logic                  resp_valid,
   output var  logic [15:0]           resp_data,
   output var  logic                  resp_err,
   // flash pins
   output var  flash_host_pkg::pins_t pins,
   input  wire logic [15:0]           dq_in
);
   typedef enum logic [2:0] {
      ST_RST_LOW,
      ST_RST_WAIT,
      ST_IDLE,
      ST_WR_SETUP,
      ST_WR_LOW,
      ST_WR_HIGH,
      ST_RD
   } state_t;

   state_t      state_r;
   logic [8:0]  cnt_r;
   logic [1:0]  id_step_r;
   logic [20:0] id_base_r;
   logic        busy_r;
   logic [5:0]  busy_bank_r;
   logic [20:0] busy_addr_r;
   logic [8:0]  wait_cnt_r;
   logic [8:0]  low_cnt_r;
   logic        take;
   logic        refuse_rd;
   logic [20:0] wr_addr;
   logic [7:0]  wr_data;

   function automatic logic [5:0] bank_of(input logic [20:0] a);
      return a[flash_host_pkg::BANK_HI:flash_host_pkg::BANK_LO];
   endfunction

   // ==========================================================
   // request decode
   assign take = (state_r == ST_IDLE) && req_valid && req_ready;
   assign refuse_rd = busy_r && (bank_of(req.addr) == busy_bank_r)
                      && (req.addr != busy_addr_r);

   always_comb begin
      wr_addr = req.addr;
      wr_data = req.data[7:0];
      unique case (req.op)
         flash_host_pkg::OP_SW_RESET: begin
            wr_data = CMD_RESET;
         end
         flash_host_pkg::OP_ID_ENTER: begin
            wr_addr = UNLOCK_ADDR_A;
            wr_data = CMD_UNLOCK_A;
         end
         default: begin
         end
      endcase
   end

   // ==========================================================
   // pin sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r   <= ST_RST_LOW;
         cnt_r     <= 9'h000;
         id_step_r <= 2'h0;
         id_base_r <= 21'h000000;
         req_ready <= 1'b0;
         resp_valid <= 1'b0;
         resp_data <= 16'h0000;
         resp_err  <= 1'b0;
         pins      <= '{flash_chip_select_n: 1'b1, oe_n: 1'b1,
                        we_n: 1'b1, reset_n: 1'b0, addr: 21'h000000,
                        dq_out: 16'h0000, dq_oe: 1'b0};
      end else begin
         resp_valid <= 1'b0;
         unique case (state_r)
            ST_RST_LOW: begin
               if (cnt_r == flash_host_pkg::RESET_PULSE_CYC
                            - flash_host_pkg::CNT_ONE) begin
                  cnt_r        <= 9'h000;
                  pins.reset_n <= 1'b1;
                  state_r      <= ST_RST_WAIT;
               end else begin
                  cnt_r <= cnt_r + flash_host_pkg::CNT_ONE;
               end
            end
            ST_RST_WAIT: begin
               if (cnt_r == flash_host_pkg::RESET_READY_CYC
                            - flash_host_pkg::CNT_ONE) begin
                  cnt_r     <= 9'h000;
                  req_ready <= 1'b1;
                  state_r   <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r + flash_host_pkg::CNT_ONE;
               end
            end
            ST_IDLE: begin
               if (take) begin
                  cnt_r <= 9'h000;
                  unique case (req.op)
                     flash_host_pkg::OP_READ: begin
                        if (refuse_rd) begin
                           resp_valid <= 1'b1;
                           resp_err   <= 1'b1;
                        end else begin
                           req_ready                <= 1'b0;
                           pins.addr                <= req.addr;
                           pins.flash_chip_select_n <= 1'b0;
                           pins.oe_n                <= 1'b0;
                           state_r                  <= ST_RD;
                        end
                     end
                     flash_host_pkg::OP_HW_RESET: begin
                        req_ready    <= 1'b0;
                        pins.reset_n <= 1'b0;
                        state_r      <= ST_RST_LOW;
                     end
                     flash_host_pkg::OP_WRITE,
                     flash_host_pkg::OP_SW_RESET,
                     flash_host_pkg::OP_ID_ENTER: begin
                        req_ready                <= 1'b0;
                        id_step_r <= (req.op == flash_host_pkg::OP_ID_ENTER)
                                     ? 2'h1 : 2'h0;
                        id_base_r                <= req.addr;
                        pins.addr                <= wr_addr;
                        pins.dq_out              <= {8'h00, wr_data};
                        pins.dq_oe               <= 1'b1;
                        pins.flash_chip_select_n <= 1'b0;
                        state_r                  <= ST_WR_SETUP;
                     end
                     default: begin
                        resp_valid <= 1'b1;
                        resp_err   <= 1'b1;
                     end
                  endcase
               end
            end
            ST_WR_SETUP: begin
               pins.we_n <= 1'b0;
               state_r   <= ST_WR_LOW;
            end
            ST_WR_LOW: begin
               if (cnt_r == flash_host_pkg::WE_LOW_CYC
                            - flash_host_pkg::CNT_ONE) begin
                  cnt_r     <= 9'h000;
                  pins.we_n <= 1'b1;
                  state_r   <= ST_WR_HIGH;
               end else begin
                  cnt_r <= cnt_r + flash_host_pkg::CNT_ONE;
               end
            end
            ST_WR_HIGH: begin
               if (cnt_r == flash_host_pkg::WE_HIGH_CYC
                            - flash_host_pkg::CNT_ONE) begin
                  cnt_r <= 9'h000;
                  if (id_step_r == 2'h1) begin
                     id_step_r   <= 2'h2;
                     pins.addr   <= UNLOCK_ADDR_B;
                     pins.dq_out <= {8'h00, CMD_UNLOCK_B};
                     state_r     <= ST_WR_SETUP;
                  end else if (id_step_r == 2'h2) begin
                     id_step_r   <= 2'h0;
                     pins.addr   <= {bank_of(id_base_r), UNLOCK_ADDR_A[14:0]};
                     pins.dq_out <= {8'h00, CMD_ID};
                     state_r     <= ST_WR_SETUP;
                  end else begin
                     pins.flash_chip_select_n <= 1'b1;
                     pins.dq_oe               <= 1'b0;
                     req_ready                <= 1'b1;
                     resp_valid               <= 1'b1;
                     resp_err                 <= 1'b0;
                     state_r                  <= ST_IDLE;
                  end
               end else begin
                  cnt_r <= cnt_r + flash_host_pkg::CNT_ONE;
               end
            end
            ST_RD: begin
               if (cnt_r == flash_host_pkg::ACCESS_CYC
                            - flash_host_pkg::CNT_ONE) begin
                  cnt_r                    <= 9'h000;
                  resp_data                <= dq_in;
                  resp_valid               <= 1'b1;
                  resp_err                 <= 1'b0;
                  req_ready                <= 1'b1;
                  pins.flash_chip_select_n <= 1'b1;
                  pins.oe_n                <= 1'b1;
                  state_r                  <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r + flash_host_pkg::CNT_ONE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // busy bank tracking
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_r      <= 1'b0;
         busy_bank_r <= 6'h00;
         busy_addr_r <= 21'h000000;
      end else if (state_r == ST_RST_LOW) begin
         busy_r <= 1'b0;
      end else if (take && req.op == flash_host_pkg::OP_WRITE
                   && req.start_op) begin
         busy_r      <= 1'b1;
         busy_bank_r <= bank_of(req.addr);
         busy_addr_r <= req.addr;
      end else if (op_done) begin
         busy_r <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_cnt_r <= 9'h000;
         low_cnt_r  <= 9'h000;
      end else if (!pins.reset_n) begin
         wait_cnt_r <= 9'h000;
         if (low_cnt_r != flash_host_pkg::CNT_SAT) begin
            low_cnt_r <= low_cnt_r + flash_host_pkg::CNT_ONE;
         end
      end else begin
         low_cnt_r <= 9'h000;
         if (wait_cnt_r != flash_host_pkg::CNT_SAT) begin
            wait_cnt_r <= wait_cnt_r + flash_host_pkg::CNT_ONE;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_read_hold;
      !pins.oe_n [*2] ##1 (pins.oe_n && resp_valid && !resp_err);
   endsequence

   a_reset_width: assert property ($rose(pins.reset_n) |->
      low_cnt_r >= flash_host_pkg::RESET_PULSE_CYC)
      else $error("reset pulse too short");
   a_ready_delay: assert property ($rose(req_ready) |->
      wait_cnt_r >= flash_host_pkg::RESET_READY_CYC)
      else $error("request accepted before read mode");
   a_reset_quiet: assert property (!pins.reset_n |->
      pins.flash_chip_select_n && !pins.dq_oe)
      else $error("pins active during reset");
   a_cmd_byte: assert property (pins.dq_oe |->
      pins.dq_out[15:8] == 8'h00)
      else $error("upper data lines driven");
   a_no_contention: assert property (!pins.oe_n |-> !pins.dq_oe)
      else $error("host drives data during read");
   a_we_gating: assert property (!pins.we_n |->
      !pins.flash_chip_select_n && pins.oe_n)
      else $error("strobe low without select");
   a_we_pulse: assert property ($fell(pins.we_n) |=> pins.we_n
      && !pins.flash_chip_select_n && pins.dq_oe)
      else $error("data not held at strobe rise");
   a_read_sample: assert property ($fell(pins.oe_n) |-> s_read_hold)
      else $error("read access time wrong");
   a_busy_refuse: assert property (take && req.op == flash_host_pkg::OP_READ
      && refuse_rd |=> resp_valid && resp_err && req_ready)
      else $error("read of busy bank not refused");
endmodule
`default_nettype wire

// File: testbench/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter logic [15:0] MAKER  = 16'h3D5A, // arbitrary value
   parameter logic [15:0] DEVICE = 16'h91E4  // arbitrary value
) (
   // host pins
   input  wire flash_host_pkg::pins_t pins,
   // data towards host and fault flag
   output var  logic [15:0]           dq_in,
   output var  logic                  proto_err
);
   // ==========================================================
   // mode state
   // one id flag per bank code, no multi-bank erase
   logic [63:0] id_bank;
   logic [1:0]  seq;
   logic [20:0] cmd_addr;
   logic [15:0] last;
   realtime     rst_fall;
   initial begin
      id_bank   = '0;
      seq       = 2'h0;
      last      = 16'h0000;
      rst_fall  = 0.0;
      proto_err = 1'b0;
      dq_in     = 16'hFFFF;
   end
   // read mode once reset high and ready time passed
   function automatic logic ready();
      return pins.reset_n === 1'b1 && $realtime - rst_fall >= 20000.0;
   endfunction
   // codes at base of id banks
   function automatic logic [15:0] word(input logic [20:0] a);
      if (id_bank[a[20:15]] && a[14:0] == 15'h0000) return MAKER;
      if (id_bank[a[20:15]] && a[14:0] == 15'h0001) return DEVICE;
      return {a[20:13], a[7:0]} ^ 16'h6C39;
   endfunction
   task automatic take_cmd(input logic [7:0] d, input logic [20:0] a);
      if (d == 8'hF0) begin
         id_bank = '0;
         seq     = 2'h0;
      end else if (seq == 2'h0 && d == 8'hAA && a[14:0] == 15'h0555) begin
         seq = 2'h1;
      end else if (seq == 2'h1 && d == 8'h55 && a[14:0] == 15'h02AA) begin
         seq = 2'h2;
      end else if (seq == 2'h2 && d == 8'h90 && a[14:0] == 15'h0555) begin
         id_bank[a[20:15]] = 1'b1;
         seq               = 2'h0;
      end else begin
         seq = 2'h0;
      end
   endtask
   // ==========================================================
   // reset pin
   // reset aborts and leaves every mode
   always @(negedge pins.reset_n) begin
      rst_fall = $realtime;
      id_bank  = '0;
      seq      = 2'h0;
   end
   // short reset pulse is a fault
   always @(posedge pins.reset_n) begin
      if ($realtime - rst_fall < 500.0) proto_err = 1'b1;
   end
   // ==========================================================
   // command writes
   // address on falling strobe
   always @(negedge pins.we_n) begin
      if (pins.flash_chip_select_n === 1'b0) cmd_addr = pins.addr;
   end
   always @(posedge pins.we_n) begin
      if (pins.flash_chip_select_n === 1'b0 && ready())
         take_cmd(pins.dq_out[7:0], cmd_addr);
   end
   // ==========================================================
   // read data
   // word only while selected, enabled and ready, else inverted last word
   always @(pins or id_bank) begin
      if (pins.oe_n === 1'b0 && pins.dq_oe === 1'b1) proto_err = 1'b1;
      if (pins.oe_n === 1'b0 && pins.flash_chip_select_n === 1'b0 && ready())
      begin
         dq_in = word(pins.addr);
         last  = dq_in;
      end else begin
         dq_in = ~last;
      end
   end
endmodule
`default_nettype wire

// File: testbench/flash_bank_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_bank_mode_control_bench;
   // ==========================================================
   // signals
   localparam logic [15:0] MAKER  = 16'h3D5A; // arbitrary value
   localparam logic [15:0] DEVICE = 16'h91E4; // arbitrary value
   logic                  clk;
   logic                  arst_n;
   logic                  req_valid;
   flash_host_pkg::req_t  req;
   logic                  req_ready;
   logic                  op_done;
   logic                  resp_valid;
   logic [15:0]           resp_data;
   logic                  resp_err;
   flash_host_pkg::pins_t pins;
   logic [15:0]           dq_in;
   logic                  proto_err;
   logic [31:0]           seed;
   logic [63:0]           id_exp;
   logic [31:0]           r;
   logic [20:0]           a;
   int                    bad_count = 0;
   int                    check_count = 0;
   int                    lat;
   int                    ref_lat;
   int                    n;
   int                    k;
   flash_host_ctrl dut (
      .clk        (clk),
      .arst_n     (arst_n),
      .req_valid  (req_valid),
      .req        (req),
      .req_ready  (req_ready),
      .op_done    (op_done),
      .resp_valid (resp_valid),
      .resp_data  (resp_data),
      .resp_err   (resp_err),
      .pins       (pins),
      .dq_in      (dq_in)
   );
   flash_dev_model #(.MAKER(MAKER), .DEVICE(DEVICE)) u_flash (
      .pins      (pins),
      .dq_in     (dq_in),
      .proto_err (proto_err)
   );
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] exp_word(input logic [20:0] ad);
      if (id_exp[ad[20:15]] && ad[14:0] == 15'h0000) return MAKER;
      if (id_exp[ad[20:15]] && ad[14:0] == 15'h0001) return DEVICE;
      return {ad[20:13], ad[7:0]} ^ 16'h6C39;
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ready();
      n = 0;
      while (req_ready !== 1'b1 && n < 600) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (req_ready !== 1'b1) begin
         chk(16'h0000, 16'h0001);
         report_and_stop();
      end
   endtask
   task automatic do_req(input logic [2:0] op, input logic st,
                         input logic [20:0] ad, input logic [15:0] d,
                         input int bound, output int lt);
      @(posedge clk);
      #1;
      wait_ready();
      req       = '{flash_host_pkg::op_t'(op), st, ad, d};
      req_valid = 1'b1;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      lt        = 0;
      if (bound > 0) begin
         while (resp_valid !== 1'b1 && lt < 20) begin
            @(posedge clk);
            #1;
            lt++;
         end
         chk(16'(resp_valid), 16'h0001);
         chk(16'(lt <= bound), 16'h0001);
         if (resp_valid !== 1'b1) begin
            report_and_stop();
         end
      end
   endtask
   task automatic rd(input logic [20:0] ad, input logic e, output int lt);
      do_req(3'h0, 1'b0, ad, 16'h0000, e ? 1 : 3, lt);
      chk(16'(resp_err), 16'(e));
      if (!e) chk(resp_data, exp_word(ad));
   endtask
   task automatic wr_seq(input logic [5:0] base, input logic bad);
      r = rnd();
      do_req(3'h1, 1'b0, 21'h000555, {r[15:8], 8'hAA}, 3, lat);
      if (bad) do_req(3'h1, 1'b0, 21'h000123, 16'h003C, 3, lat);
      do_req(3'h1, 1'b0, 21'h0002AA, {r[31:24], 8'h55}, 3, lat);
      do_req(3'h1, 1'b0, {base, 15'h0555}, {r[7:0], 8'h90}, 3, lat);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      seed      = 32'h0000EA75;
      arst_n    = 1'b0;
      req_valid = 1'b0;
      req       = '0;
      op_done   = 1'b0;
      id_exp    = '0;
      repeat (16) @(posedge clk);
      chk({12'h000, pins.reset_n, pins.flash_chip_select_n, pins.dq_oe,
           req_ready}, 16'h0004);
      #1;
      arst_n = 1'b1;
      wait_ready();
      chk(16'(n >= 400), 16'h0001);
      rd(21'h000000, 1'b0, ref_lat);
      for (k = 0; k < 16; k++) begin
         r = rnd();
         rd(r[20:0], 1'b0, lat);
      end
      for (k = 0; k < 3; k++) begin
         r = rnd();
         a = {(k == 0) ? 6'h00 : (k == 1) ? 6'h3F : r[5:0], 15'h0000};
         do_req(3'h4, 1'b0, a, 16'h0000, 9, lat);
         id_exp[a[20:15]] = 1'b1;
         rd(a, 1'b0, lat);
         chk(16'(lat), 16'(ref_lat));
         rd(a + 21'h000001, 1'b0, lat);
         rd(a + 21'h000002, 1'b0, lat);
         rd(a + 21'h008000, 1'b0, lat);
      end
      r = rnd();
      do_req(3'h2, 1'b0, r[20:0], 16'h0000, 3, lat);
      id_exp = '0;
      rd(a, 1'b0, lat);
      wr_seq(6'h05, 1'b0);
      id_exp[5] = 1'b1;
      rd({6'h05, 15'h0001}, 1'b0, lat);
      wr_seq(6'h06, 1'b1);
      rd({6'h06, 15'h0000}, 1'b0, lat);
      r = rnd();
      a = r[20:0];
      do_req(3'h1, 1'b1, a, r[31:16], 3, lat);
      rd(a ^ 21'h000010, 1'b1, lat);
      rd(a, 1'b0, lat);
      rd(a ^ 21'h100000, 1'b0, lat);
      op_done = 1'b1;
      @(posedge clk);
      #1;
      op_done = 1'b0;
      rd(a ^ 21'h000010, 1'b0, lat);
      for (k = 5; k < 8; k++) begin
         do_req(3'(k), 1'b0, 21'h000000, 16'h0000, 1, lat);
         chk(16'(resp_err), 16'h0001);
      end
      do_req(3'h1, 1'b1, a, 16'h0000, 3, lat);
      do_req(3'h3, 1'b0, a, 16'h0000, 0, lat);
      id_exp = '0;
      rd({6'h05, 15'h0001}, 1'b0, lat);
      rd(a ^ 21'h000010, 1'b0, lat);
      chk(16'(proto_err), 16'h0000);
      report_and_stop();
   end
endmodule
`default_nettype wire
